// >>> verilog/dac_serial_port.sv
// Serial write port of a dual converter, oversampled by the system clock
`timescale 1ns/10ps
module dac_serial_port (
	input  wire logic         SYS_CLK,
	input  wire logic         RST,
	input  wire logic         SCLK,
	input  wire logic         DIN,
	input  wire logic         SYNC_N,
	input  wire logic         LOAD_STROBE_N,
	input  wire logic         APPLY_READY,
	output logic              SERIAL_DATA_OUT,
	output logic [11:0]       DAC_A_CODE,
	output logic [11:0]       DAC_B_CODE,
	output logic              CHAIN_MODE,
	output logic              RISING_MODE,
	output logic              OVERRUN
);

	dac_port_pkg::state_t s;
	dac_port_pkg::state_t next_s;
	dac_port_pkg::word_t  head;
	logic                 sclk_rise;
	logic                 sclk_fall;
	logic                 active_edge;
	logic                 other_edge;
	logic                 sync_low;
	logic                 sync_fall;
	logic                 sync_rise;
	logic                 strobe_low;
	logic                 strobe_fall;
	logic                 pop;

	// Edge finders read second synchroniser stages and their delayed copies
	assign sclk_rise   = s.sclk_s[1] & ~s.sclk_d;
	assign sclk_fall   = ~s.sclk_s[1] & s.sclk_d;
	assign active_edge = s.rising ? sclk_rise : sclk_fall;
	assign other_edge  = s.rising ? sclk_fall : sclk_rise;
	assign sync_low    = ~s.sync_s[1];
	assign sync_fall   = ~s.sync_s[1] & s.sync_d;
	assign sync_rise   = s.sync_s[1] & ~s.sync_d;
	assign strobe_low  = ~s.strobe_s[1];
	assign strobe_fall = ~s.strobe_s[1] & s.strobe_d;
	assign head        = s.slot[s.rd_ptr];
	// Drain stalls while the output side is busy
	assign pop         = (s.fill != 2'h0) & APPLY_READY;

	// Next-state logic for the whole port
	always_comb
	begin
		logic                push;
		logic                push_ok;
		dac_port_pkg::word_t push_word;
		next_s    = s;
		push      = 1'b0;
		push_ok   = 1'b0;
		push_word = s.shift;
		next_s.sclk_s  = {s.sclk_s[0], SCLK};
		next_s.din_s   = {s.din_s[0], DIN};
		next_s.sync_s  = {s.sync_s[0], SYNC_N};
		next_s.strobe_s = {s.strobe_s[0], LOAD_STROBE_N};
		next_s.sclk_d  = s.sclk_s[1];
		next_s.sync_d  = s.sync_s[1];
		next_s.strobe_d = s.strobe_s[1];
		next_s.overrun = 1'b0;

		// Frame start rearms the counter; mid-word it drops the word
		if (sync_fall)
			next_s.count = dac_port_pkg::CNT_RST;
		else if (sync_low && active_edge &&
			(s.chain || s.count != dac_port_pkg::WORD_BITS))
		begin
			next_s.shift = {s.shift[14:0], s.din_s[1]};
			if (s.count != dac_port_pkg::WORD_BITS)
				next_s.count = s.count + 5'h01;
			// Standalone word completes on the sixteenth edge
			if (!s.chain && s.count == dac_port_pkg::LAST_BIT)
			begin
				push      = 1'b1;
				push_word = {s.shift[14:0], s.din_s[1]};
			end
		end

		// Readback shifts on the edge opposite to sampling
		if (sync_low && other_edge)
			next_s.data_out = s.shift[15];

		// Chained word is taken when the frame closes
		if (sync_rise && s.chain && s.count == dac_port_pkg::WORD_BITS)
		begin
			push      = 1'b1;
			push_word = s.shift;
		end

		// Strobe falling edge copies input registers to outputs
		if (strobe_fall)
		begin
			next_s.dac_a = s.in_a;
			next_s.dac_b = s.in_b;
		end

		// Execute the oldest buffered word
		if (pop)
		begin
			next_s.rd_ptr = ~s.rd_ptr;
			case (head.cmd)
				dac_port_pkg::CMD_LDUPD_A:
				begin
					next_s.in_a  = head.code;
					next_s.dac_a = head.code;
				end
				dac_port_pkg::CMD_LDUPD_B:
				begin
					next_s.in_b  = head.code;
					next_s.dac_b = head.code;
				end
				dac_port_pkg::CMD_LDIN_A:
				begin
					next_s.in_a = head.code;
					if (strobe_low)
						next_s.dac_a = head.code;
				end
				dac_port_pkg::CMD_LDIN_B:
				begin
					next_s.in_b = head.code;
					if (strobe_low)
						next_s.dac_b = head.code;
				end
				dac_port_pkg::CMD_LDIN_AB:
				begin
					next_s.in_a = head.code;
					next_s.in_b = head.code;
					if (strobe_low)
					begin
						next_s.dac_a = head.code;
						next_s.dac_b = head.code;
					end
				end
				dac_port_pkg::CMD_UPD_AB:
				begin
					next_s.dac_a = s.in_a;
					next_s.dac_b = s.in_b;
				end
				dac_port_pkg::CMD_CHAIN_OFF: next_s.chain  = 1'b0;
				dac_port_pkg::CMD_RISE_EDGE: next_s.rising = 1'b1;
				dac_port_pkg::CMD_CLR_ZERO:
				begin
					next_s.in_a  = dac_port_pkg::CODE_ZERO;
					next_s.in_b  = dac_port_pkg::CODE_ZERO;
					next_s.dac_a = dac_port_pkg::CODE_ZERO;
					next_s.dac_b = dac_port_pkg::CODE_ZERO;
				end
				dac_port_pkg::CMD_CLR_MID:
				begin
					next_s.in_a  = dac_port_pkg::CODE_MID;
					next_s.in_b  = dac_port_pkg::CODE_MID;
					next_s.dac_a = dac_port_pkg::CODE_MID;
					next_s.dac_b = dac_port_pkg::CODE_MID;
				end
				default: ;
			endcase
		end

		// Host cannot be stalled, so a full buffer flags the lost word
		push_ok = push && (s.fill != dac_port_pkg::FILL_FULL);
		if (push && !push_ok)
			next_s.overrun = 1'b1;
		if (push_ok)
		begin
			next_s.slot[s.wr_ptr] = push_word;
			next_s.wr_ptr         = ~s.wr_ptr;
		end
		next_s.fill = s.fill + {1'b0, push_ok} - {1'b0, pop};
	end

	// State register
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			s        <= '0;
			s.sclk_s <= 2'h0;
			s.sync_s <= 2'h3;
			s.strobe_s <= 2'h3;
			s.sync_d <= 1'b1;
			s.strobe_d <= 1'b1;
			s.chain  <= dac_port_pkg::CHAIN_RST;
			s.rising <= dac_port_pkg::RISE_RST;
		end
		else
			s <= next_s;
	end

	assign SERIAL_DATA_OUT = s.data_out;
	assign DAC_A_CODE      = s.dac_a;
	assign DAC_B_CODE      = s.dac_b;
	assign CHAIN_MODE      = s.chain;
	assign RISING_MODE     = s.rising;
	assign OVERRUN         = s.overrun;

	// Checks on the port behaviour
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	sequence framed_word_end;
		!s.chain && sync_low && active_edge && !sync_fall &&
			s.count == dac_port_pkg::LAST_BIT;
	endsequence

	AST_ABORT_ON_SYNC: assert property (
		sync_fall |=> s.count == dac_port_pkg::CNT_RST)
		else $error("Frame sync edge did not restart the bit count");
	AST_SIXTEENTH_EDGE: assert property (
		framed_word_end |=> s.count == dac_port_pkg::WORD_BITS &&
			(s.fill != 2'h0 || OVERRUN || $past(pop)))
		else $error("Standalone word not taken on sixteenth edge");
	AST_HOLD_AFTER_WORD: assert property (
		!s.chain && s.count == dac_port_pkg::WORD_BITS && !sync_fall
			|=> $stable(s.shift))
		else $error("Standalone shift register moved past sixteen bits");
	AST_CHAIN_CLOSE: assert property (
		s.chain && sync_rise && s.count == dac_port_pkg::WORD_BITS &&
			s.fill == 2'h0 ##0 !APPLY_READY
			|=> s.fill == 2'h1 && s.slot[$past(s.wr_ptr)] == $past(s.shift))
		else $error("Chained word not buffered at frame close");
	AST_LOAD_UPDATE: assert property (
		pop && head.cmd == dac_port_pkg::CMD_LDUPD_A
			|=> DAC_A_CODE == $past(head.code))
		else $error("Load-and-update did not reach output A");
	AST_SAMPLE_EDGE: assert property (
		!s.rising && sclk_rise && !sync_fall |=> $stable(s.shift))
		else $error("Data sampled on rising edge in falling mode");
	AST_READBACK: assert property (
		sync_low && other_edge |=> SERIAL_DATA_OUT == $past(s.shift[15]))
		else $error("Readback bit not driven on the opposite edge");
	AST_FIELD_SPLIT: assert property (
		pop && head.cmd == dac_port_pkg::CMD_LDIN_B
			|=> s.in_b == $past(head.code))
		else $error("Code field not loaded into input register B");
	AST_IDLE_FRAME: assert property (
		!sync_low && !sync_rise |=> $stable(s.shift) [*2])
		else $error("Shift register moved outside a frame");

endmodule : dac_serial_port

// >>> shared/dac_port_pkg.sv
// Constants, carrier types and state record of the converter serial port
// Overview of operation
// - Load-and-update command updates the addressed output whatever the strobe level
// - Standalone frames stop after one sixteen-bit word; chained frames keep shifting in
// - Data is sampled on falling serial clock edges unless a command selects rising
// - Frame-timed update happens on the frame sync rising edge closing the word
// - While framed, shift register contents leave on data out at edges opposite to sampling
// - Each word is four command bits followed by twelve data bits
// - With strobe low, output updates at sixteenth edge or at frame end chained
// - In standalone mode a frame sync edge mid-word aborts that write
package dac_port_pkg;

	localparam int        WORD_W     = 16;
	localparam int        CODE_W     = 12;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [4:0] LAST_BIT  = 5'h0f;
	localparam logic [4:0] CNT_RST   = 5'h00;
	localparam logic [1:0] FILL_FULL = 2'h2;

	// Command codes in the top four bits of a word
	localparam logic [3:0] CMD_NOP       = 4'h0;
	localparam logic [3:0] CMD_LDUPD_A   = 4'h1;
	localparam logic [3:0] CMD_LDIN_A    = 4'h3;
	localparam logic [3:0] CMD_LDUPD_B   = 4'h4;
	localparam logic [3:0] CMD_LDIN_B    = 4'h6;
	localparam logic [3:0] CMD_UPD_AB    = 4'h7;
	localparam logic [3:0] CMD_LDIN_AB   = 4'h8;
	localparam logic [3:0] CMD_CHAIN_OFF = 4'h9;
	localparam logic [3:0] CMD_RISE_EDGE = 4'ha;
	localparam logic [3:0] CMD_CLR_ZERO  = 4'hb;
	localparam logic [3:0] CMD_CLR_MID   = 4'hc;

	localparam logic [11:0] CODE_ZERO = 12'h000;
	localparam logic [11:0] CODE_MID  = 12'h800;

	// Values after reset
	localparam logic CHAIN_RST = 1'b1;
	localparam logic RISE_RST  = 1'b0;

	typedef struct packed {
		logic [3:0]  cmd;
		logic [11:0] code;
	} word_t;

	typedef struct packed {
		logic [1:0]      sclk_s;
		logic [1:0]      din_s;
		logic [1:0]      sync_s;
		logic [1:0]      strobe_s;
		logic            sclk_d;
		logic            sync_d;
		logic            strobe_d;
		logic [15:0]     shift;
		logic [4:0]      count;
		logic            chain;
		logic            rising;
		logic            data_out;
		word_t [1:0]     slot;
		logic            wr_ptr;
		logic            rd_ptr;
		logic [1:0]      fill;
		logic [11:0]     in_a;
		logic [11:0]     in_b;
		logic [11:0]     dac_a;
		logic [11:0]     dac_b;
		logic            overrun;
	} state_t;

endpackage : dac_port_pkg

// >>> tb/host_serial_model.sv
// Host serial port model driving the converter frame pins
`timescale 1ns/10ps
module host_serial_model (
	input  wire logic clk,
	input  wire logic data_out,
	output logic      sclk,
	output logic      din,
	output logic      sync_n
);
	logic [15:0] readback;
	bit          inv = 1'b0;

	// Idle pins: clock parked low, frame closed
	initial
	begin
		sclk = 1'b0;
		din = 1'b0;
		sync_n = 1'b1;
		readback = 16'h0000;
	end

	// Half serial period, 80 ns at the system rate
	task automatic half;
		repeat (20) @(negedge clk);
	endtask : half

	// Sends the top nbits of w, optionally as two byte bursts
	task automatic send(input logic [15:0] w, input int nbits,
		input bit split);
		sync_n = 1'b0;
		// Rising-edge device needs the first bit before the first edge
		if (inv)
			din = w[15];
		half();
		for (int i = 15; i > 15 - nbits; i--)
		begin
			sclk = 1'b1;
			if (!inv)
				din = w[i];
			half();
			// Readback bit settled long before this sample
			readback = {readback[14:0], data_out};
			sclk = 1'b0;
			if (inv && i > 16 - nbits)
				din = w[i - 1];
			half();
			if (split && i == 8)
				repeat (4) half();
		end
		sync_n = 1'b1;
		din = ~din; // Released line must not show the last bit
		// Host follows the sampling edge it selected itself
		if (nbits == 16 && w[15:12] == dac_port_pkg::CMD_RISE_EDGE)
			inv = 1'b1;
		half();
	endtask : send
endmodule : host_serial_model

// >>> tb/dual_dac_serial_write_port_tb.sv
// Self-checking bench for the converter serial write port
`timescale 1ns/10ps
module dual_dac_serial_write_port_tb;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        sclk;
	logic        din;
	logic        sync_n;
	logic        load_strobe_n = 1'b1;
	logic        apply_ready = 1'b1;
	logic        data_out;
	logic        chain_mode;
	logic        rising_mode;
	logic        overrun;
	logic [11:0] dac_a;
	logic [11:0] dac_b;
	logic        overrun_seen = 1'b0;
	int          fail_count = 0;
	int          check_count = 0;

	always #2 sys_clk = ~sys_clk;

	// Pulse is one cycle wide, so keep it for a later look
	always @(posedge sys_clk)
		if (overrun === 1'b1)
			overrun_seen <= 1'b1;

	host_serial_model host (
		.clk      (sys_clk),
		.data_out (data_out),
		.sclk     (sclk),
		.din      (din),
		.sync_n   (sync_n)
	);

	dac_serial_port dut (
		.SYS_CLK         (sys_clk),
		.RST             (rst),
		.SCLK            (sclk),
		.DIN             (din),
		.SYNC_N          (sync_n),
		.LOAD_STROBE_N   (load_strobe_n),
		.APPLY_READY     (apply_ready),
		.SERIAL_DATA_OUT (data_out),
		.DAC_A_CODE      (dac_a),
		.DAC_B_CODE      (dac_b),
		.CHAIN_MODE      (chain_mode),
		.RISING_MODE     (rising_mode),
		.OVERRUN         (overrun)
	);

	task automatic print_verdict;
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	// Polls for up to 40 cycles; a value never reached is a mismatch
	task automatic check(input string nm, input logic [11:0] exp,
		input int sel);
		logic [11:0] got;
		for (int n = 0; n < 40; n++)
		begin
			@(negedge sys_clk);
			case (sel)
				0: got = dac_a;
				1: got = dac_b;
				2: got = {10'h000, chain_mode, rising_mode};
				default: got = {11'h000, overrun_seen};
			endcase
			if (got === exp)
				break;
		end
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	// Readback of a frame mirrors the word held before it
	task automatic check_readback(input logic [15:0] exp);
		check_count++;
		if (host.readback !== exp)
		begin
			fail_count++;
			$display("[ERR] readback expected %h seen %h", exp,
				host.readback);
		end
	endtask : check_readback

	// Power-up: zero codes, chained, falling-edge sampling
	task automatic reset_state;
		check("dac_a", 12'h000, 0);
		check("dac_b", 12'h000, 1);
		check("modes", 12'h002, 2);
	endtask : reset_state

	// Whole word, then a word made of two byte bursts
	task automatic chained_writes;
		host.send(16'h1abc, 16, 1'b0);
		check("dac_a", 12'habc, 0);
		host.send(16'h45a5, 16, 1'b1);
		check("dac_b", 12'h5a5, 1);
	endtask : chained_writes

	// Input load waits for the strobe; clear sets both to midscale
	task automatic strobe_update;
		host.send(16'h3777, 16, 1'b0);
		check("dac_a held", 12'habc, 0);
		load_strobe_n = 1'b0;
		check("dac_a strobed", 12'h777, 0);
		load_strobe_n = 1'b1;
		host.send(16'hc000, 16, 1'b0);
		check("dac_a mid", 12'h800, 0);
		check("dac_b mid", 12'h800, 1);
	endtask : strobe_update

	// Strobe low loads at once; clear, then both-channel load and update
	task automatic load_both;
		load_strobe_n = 1'b0;
		host.send(16'h6123, 16, 1'b0);
		load_strobe_n = 1'b1;
		check("dac_b loaded", 12'h123, 1);
		host.send(16'hb000, 16, 1'b0);
		check("dac_a zero", 12'h000, 0);
		check("dac_b zero", 12'h000, 1);
		host.send(16'h8800, 16, 1'b0);
		check("dac_b held", 12'h000, 1);
		host.send(16'h7000, 16, 1'b0);
		check_readback(16'h8800);
		check("dac_a both", 12'h800, 0);
		check("dac_b both", 12'h800, 1);
	endtask : load_both

	// Stalled drain: two words held, the third is lost
	task automatic buffer_full;
		apply_ready = 1'b0;
		host.send(16'h1111, 16, 1'b0);
		host.send(16'h4222, 16, 1'b0);
		check_readback(16'h1111);
		host.send(16'h1333, 16, 1'b0);
		check("overrun", 12'h001, 3);
		check("dac_a stalled", 12'h800, 0);
		apply_ready = 1'b1;
		check("dac_a drained", 12'h111, 0);
		check("dac_b drained", 12'h222, 1);
	endtask : buffer_full

	// Standalone: a cut frame stores nothing, then rising-edge mode
	task automatic standalone;
		host.send(16'h9000, 16, 1'b0);
		check("chain off", 12'h000, 2);
		host.send(16'h1fff, 8, 1'b0);
		host.send(16'h4321, 16, 1'b0);
		check("dac_a abort", 12'h111, 0);
		check("dac_b", 12'h321, 1);
		host.send(16'ha000, 16, 1'b0);
		check("rising", 12'h001, 2);
		host.send(16'h4456, 16, 1'b0);
		check("dac_b rising", 12'h456, 1);
	endtask : standalone

	initial
	begin
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		reset_state();
		chained_writes();
		strobe_update();
		load_both();
		buffer_full();
		standalone();
		print_verdict();
	end
endmodule : dual_dac_serial_write_port_tb
